// file: hw/home_seq_pkg.sv
// constants, register map and carrier types for the return-to-home sequencer
// assumes one 40 MHz core clock and a step generator that reports each issued step
package home_seq_pkg;

  localparam int SPEED_W = 20;
  localparam int OFS_W = 24;

  // register byte addresses on the apb bus
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] START_SPEED_ADDR = 8'h04;
  localparam logic [7:0] RUN_SPEED_ADDR = 8'h08;
  localparam logic [7:0] OFFSET_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_DIR_BIT = 3;
  localparam int CTRL_SENSOR_INPUT_A_EN_BIT = 4;
  localparam int CTRL_TIM_EN_BIT = 5;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_STATE_LSB = 8;

  // homing mode codes
  localparam logic [1:0] MODE_TWO_SENSOR = 2'h0;
  localparam logic [1:0] MODE_THREE_SENSOR = 2'h1;
  localparam logic [1:0] MODE_PUSH = 2'h2;

  // reset values
  localparam logic [1:0] MODE_RESET = MODE_THREE_SENSOR;
  localparam logic DIR_RESET = 1'h1;
  localparam logic [SPEED_W-1:0] START_SPEED_RESET = 20'h001f4;
  localparam logic [SPEED_W-1:0] RUN_SPEED_RESET = 20'h003e8;
  localparam logic [OFS_W-1:0] OFFSET_RESET = 24'h000000;

  // final approach speed cap and escape travel after a limit
  localparam logic [SPEED_W-1:0] FINAL_SPEED_CAP_HZ = 20'h001f4;
  localparam logic [OFS_W-1:0] ESCAPE_STEPS = 24'h0000c8;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SEEK = 8'h02,
    ST_ESCAPE = 8'h04,
    ST_EXTRA = 8'h08,
    ST_PAUSE = 8'h10,
    ST_QUAL = 8'h20,
    ST_OFFSET = 8'h40,
    ST_DONE = 8'h80
  } seq_state_t;

  typedef struct packed {
    logic home_sensor;
    logic positive_limit_sensor;
    logic negative_limit_sensor;
    logic sensor_input_a;
    logic step_timing_signal;
  } sensor_t;

  typedef struct packed {
    logic run;
    logic dir_pos;
    logic [SPEED_W-1:0] start_speed;
    logic [SPEED_W-1:0] target_speed;
  } motion_cmd_t;

endpackage

// file: hw/return_to_home_sequencer.sv
// return-to-home sequencer: two-sensor and three-sensor homing with an apb register file
// assumes sensor levels are synchronous and active high, and step_tick pulses once per step
`timescale 1ns/100ps

// Contract
// - three-sensor qualified: continue past home until qualifier
// - three-sensor completes on qualifier while home active
// - final speed is start speed capped at 500
// - moves start at start speed, run speed
// - two-sensor: 200 more steps after leaving limit
// - two-sensor: limit reverses travel until released
// - two-sensor qualified: stop once, then seek qualifier
// - two-sensor qualified: complete when qualifier seen
// - after completion move by signed offset
// - assert homing-complete output when finished
// - mode 0 two-sensor, 1 three, 2 push; a push start only sets the error flag and does not move (the code also clears the done flag)
// - direction setting 0 negative, 1 positive
module return_to_home_sequencer
  import home_seq_pkg::*;
(
  input wire logic core_clk, // 40 MHz clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire sensor_t sensors, // limit, home and qualifier inputs
  input wire logic step_tick, // one pulse per step issued
  output motion_cmd_t motion, // run, direction and speed profile
  output logic home_done // homing complete level
);

  typedef struct packed {
    seq_state_t st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] mode;
    logic dir_cfg;
    logic sensor_input_a_en;
    logic tim_en;
    logic [SPEED_W-1:0] vs;
    logic [SPEED_W-1:0] vr;
    logic [OFS_W-1:0] ofs;
    logic [OFS_W-1:0] cnt;
    motion_cmd_t cmd;
    logic done;
    logic err;
    logic turned; // a limit has already reversed this seek
  } seq_t;

  seq_t q_r;
  seq_t q_nxt;

  logic [SPEED_W-1:0] vl;
  logic qual_en;
  logic qual_hit;
  logic limit_ahead;
  logic limit_behind;
  logic count_end;
  logic acc;
  logic wr_take;
  logic addr_ok;
  logic start_req;
  logic [OFS_W-1:0] ofs_mag;

  assign vl = (q_r.vs < FINAL_SPEED_CAP_HZ) ? q_r.vs : FINAL_SPEED_CAP_HZ;
  assign qual_en = q_r.sensor_input_a_en | q_r.tim_en;
  // with both enabled both must be present; a disabled one never blocks
  assign qual_hit = qual_en && (!q_r.sensor_input_a_en || sensors.sensor_input_a) &&
                    (!q_r.tim_en || sensors.step_timing_signal);
  assign limit_ahead = q_r.cmd.dir_pos ? sensors.positive_limit_sensor
                                       : sensors.negative_limit_sensor;
  // the limit behind is the one just left, judged against the already flipped direction
  assign limit_behind = q_r.cmd.dir_pos ? sensors.negative_limit_sensor
                                        : sensors.positive_limit_sensor;
  assign count_end = (q_r.cnt == '0) || (step_tick && q_r.cnt == OFS_W'(1));
  assign acc = psel && penable;
  assign wr_take = acc && q_r.pready && pwrite;
  assign addr_ok = (paddr == CTRL_ADDR) || (paddr == START_SPEED_ADDR) ||
                   (paddr == RUN_SPEED_ADDR) || (paddr == OFFSET_ADDR) ||
                   (paddr == STATUS_ADDR);
  // start is decoded from the same write, so mode and direction of that word apply at once
  assign start_req = wr_take && paddr == CTRL_ADDR && pwdata[CTRL_START_BIT];
  assign ofs_mag = q_r.ofs[OFS_W-1] ? OFS_W'(-q_r.ofs) : q_r.ofs;

  always_comb begin
    q_nxt = q_r;
    q_nxt.cmd.start_speed = q_r.vs;

    // apb: ready comes one cycle into the access phase, writes land on the next edge, which samples ready high
    q_nxt.pready = acc && !q_r.pready;
    q_nxt.pslverr = acc && !q_r.pready && !addr_ok;
    if (acc && !q_r.pready && !pwrite) begin
      case (paddr)
        CTRL_ADDR: begin
          q_nxt.prdata = '0;
          q_nxt.prdata[CTRL_MODE_LSB +: 2] = q_r.mode;
          q_nxt.prdata[CTRL_DIR_BIT] = q_r.dir_cfg;
          q_nxt.prdata[CTRL_SENSOR_INPUT_A_EN_BIT] = q_r.sensor_input_a_en;
          q_nxt.prdata[CTRL_TIM_EN_BIT] = q_r.tim_en;
        end
        START_SPEED_ADDR: q_nxt.prdata = 32'(q_r.vs);
        RUN_SPEED_ADDR: q_nxt.prdata = 32'(q_r.vr);
        OFFSET_ADDR: q_nxt.prdata = 32'(signed'(q_r.ofs));
        STATUS_ADDR: begin
          q_nxt.prdata = '0;
          q_nxt.prdata[STAT_BUSY_BIT] = q_r.cmd.run;
          q_nxt.prdata[STAT_DONE_BIT] = q_r.done;
          q_nxt.prdata[STAT_ERR_BIT] = q_r.err;
          q_nxt.prdata[STAT_STATE_LSB +: 8] = q_r.st;
        end
        default: q_nxt.prdata = '0;
      endcase
    end
    // settings are only taken while no homing is running, so a move never sees them change
    if (wr_take && (q_r.st == ST_IDLE || q_r.st == ST_DONE)) begin
      case (paddr)
        CTRL_ADDR: begin
          q_nxt.mode = pwdata[CTRL_MODE_LSB +: 2];
          q_nxt.dir_cfg = pwdata[CTRL_DIR_BIT];
          q_nxt.sensor_input_a_en = pwdata[CTRL_SENSOR_INPUT_A_EN_BIT];
          q_nxt.tim_en = pwdata[CTRL_TIM_EN_BIT];
        end
        START_SPEED_ADDR: q_nxt.vs = pwdata[SPEED_W-1:0];
        RUN_SPEED_ADDR: q_nxt.vr = pwdata[SPEED_W-1:0];
        OFFSET_ADDR: q_nxt.ofs = pwdata[OFS_W-1:0];
        default: ;
      endcase
    end

    case (q_r.st)
      ST_IDLE, ST_DONE: begin
        if (start_req) begin
          // push mode is not handled here: flag it and stay put
          if (pwdata[CTRL_MODE_LSB +: 2] != MODE_TWO_SENSOR &&
              pwdata[CTRL_MODE_LSB +: 2] != MODE_THREE_SENSOR) begin
            q_nxt.err = 1'b1;
            q_nxt.done = 1'b0;
            q_nxt.st = ST_IDLE;
          end else begin
            q_nxt.err = 1'b0;
            q_nxt.done = 1'b0;
            q_nxt.turned = 1'b0;
            q_nxt.cmd.run = 1'b1;
            q_nxt.cmd.dir_pos = pwdata[CTRL_DIR_BIT];
            q_nxt.cmd.target_speed = q_r.vr;
            q_nxt.st = ST_SEEK;
          end
        end
      end
      ST_SEEK: begin
        if (q_r.mode == MODE_THREE_SENSOR && sensors.home_sensor) begin
          if (qual_en) begin
            q_nxt.cmd.target_speed = vl;
            q_nxt.st = ST_QUAL;
          end else begin
            q_nxt.st = ST_OFFSET;
          end
        end else if (limit_ahead && q_r.mode == MODE_THREE_SENSOR && q_r.turned) begin
          // second limit without a home edge: stop rather than shuttle between the ends
          q_nxt.cmd.run = 1'b0;
          q_nxt.err = 1'b1;
          q_nxt.st = ST_IDLE;
        end else if (limit_ahead) begin
          q_nxt.cmd.dir_pos = !q_r.cmd.dir_pos;
          q_nxt.turned = 1'b1;
          if (q_r.mode == MODE_TWO_SENSOR) begin
            q_nxt.cmd.target_speed = vl;
            q_nxt.st = ST_ESCAPE;
          end
        end
      end
      ST_ESCAPE: begin
        if (!limit_behind) begin
          q_nxt.cnt = ESCAPE_STEPS;
          q_nxt.st = ST_EXTRA;
        end
      end
      ST_EXTRA: begin
        if (step_tick && q_r.cnt != '0) begin
          q_nxt.cnt = q_r.cnt - OFS_W'(1);
        end
        if (count_end) begin
          if (qual_en) begin
            q_nxt.cmd.run = 1'b0;
            q_nxt.st = ST_PAUSE;
          end else begin
            q_nxt.st = ST_OFFSET;
          end
        end
      end
      ST_PAUSE: begin
        // one idle cycle so the step generator sees a stop before resuming
        q_nxt.cmd.run = 1'b1;
        q_nxt.st = ST_QUAL;
      end
      ST_QUAL: begin
        // three-sensor keeps going past a home edge without a qualifier
        if (qual_hit && (q_r.mode == MODE_TWO_SENSOR || sensors.home_sensor)) begin
          q_nxt.st = ST_OFFSET;
        end else if (limit_ahead) begin
          // qualifier not met before the end of travel: search back the other way
          q_nxt.cmd.dir_pos = !q_r.cmd.dir_pos;
        end
      end
      ST_OFFSET: begin
        if (step_tick && q_r.cnt != '0) begin
          q_nxt.cnt = q_r.cnt - OFS_W'(1);
        end
        if (count_end) begin
          q_nxt.cmd.run = 1'b0;
          q_nxt.done = 1'b1;
          q_nxt.st = ST_DONE;
        end
      end
      default: q_nxt.st = ST_IDLE;
    endcase

    // entry into the offset move: load distance and direction from the signed offset
    if (q_r.st != ST_OFFSET && q_nxt.st == ST_OFFSET) begin
      q_nxt.cnt = ofs_mag;
      q_nxt.cmd.dir_pos = !q_r.ofs[OFS_W-1];
      q_nxt.cmd.target_speed = q_r.vr;
      q_nxt.cmd.run = (ofs_mag != '0);
    end

    // both limits at once is a wiring fault: no direction is safe, so stop and flag it
    if (sensors.positive_limit_sensor && sensors.negative_limit_sensor &&
        q_r.st != ST_IDLE && q_r.st != ST_DONE) begin
      q_nxt.cmd.run = 1'b0;
      q_nxt.done = 1'b0;
      q_nxt.err = 1'b1;
      q_nxt.st = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q_r.st <= ST_IDLE;
      q_r.prdata <= '0;
      q_r.pready <= 1'b0;
      q_r.pslverr <= 1'b0;
      q_r.mode <= MODE_RESET;
      q_r.dir_cfg <= DIR_RESET;
      q_r.sensor_input_a_en <= 1'b0;
      q_r.tim_en <= 1'b0;
      q_r.vs <= START_SPEED_RESET;
      q_r.vr <= RUN_SPEED_RESET;
      q_r.ofs <= OFFSET_RESET;
      q_r.cnt <= '0;
      q_r.cmd.run <= 1'b0;
      q_r.cmd.dir_pos <= DIR_RESET;
      q_r.cmd.start_speed <= START_SPEED_RESET;
      q_r.cmd.target_speed <= RUN_SPEED_RESET;
      q_r.done <= 1'b0;
      q_r.err <= 1'b0;
      q_r.turned <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign motion = q_r.cmd;
  assign home_done = q_r.done;

endmodule // return_to_home_sequencer

// file: testbench/home_seq_properties.sv
// port properties of the return-to-home sequencer
// assumes binding onto return_to_home_sequencer, one clock, synchronous reset
`timescale 1ns/100ps
module home_seq_properties
  import home_seq_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire sensor_t sensors, // sensors
  input wire logic step_tick, // step
  input wire motion_cmd_t motion, // command
  input wire logic home_done // done
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [5:0] cfg_r;
  logic go_w;
  logic qual_w;
  logic two_w;
  logic [SPEED_W-1:0] cap_w;
  // settings of the last accepted start; starts while moving are ignored
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_r <= 6'h0a;
    end else if (go_w) begin
      cfg_r <= pwdata[5:0];
    end
  end
  assign go_w = psel && penable && pready && pwrite && paddr == CTRL_ADDR
    && pwdata[0] && !motion.run;
  assign qual_w = (!cfg_r[4] || sensors.sensor_input_a)
    && (!cfg_r[5] || sensors.step_timing_signal);
  assign two_w = cfg_r[2:1] == MODE_TWO_SENSOR;
  assign cap_w = motion.start_speed < FINAL_SPEED_CAP_HZ ? motion.start_speed : FINAL_SPEED_CAP_HZ;
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready long");
  access_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("wait");
  bad_addr_a: assert property (pready |-> pslverr == (paddr > STATUS_ADDR || paddr[1:0] != 2'h0))
    else $error("pslverr");
  start_run_a: assert property (go_w && pwdata[2:1] < 2'h2 |=> motion.run && !home_done
    && motion.dir_pos == $past(pwdata[3])) else $error("start");
  push_off_a: assert property (go_w && pwdata[2:1] == MODE_PUSH |=> !motion.run)
    else $error("push");
  final_speed_a: assert property (!two_w && cfg_r[5:4] != 2'h0 && motion.run
    && $rose(sensors.home_sensor) |=> motion.target_speed == cap_w) else $error("speed");
  past_home_a: assert property (!two_w && cfg_r[5:4] != 2'h0 && motion.run
    && sensors.home_sensor && !qual_w |=> motion.run) else $error("stopped");
  limit_turn_a: assert property (two_w && motion.run && (motion.dir_pos ?
    sensors.positive_limit_sensor : sensors.negative_limit_sensor)
    |=> motion.dir_pos != $past(motion.dir_pos)) else $error("turn");
  pause_once_a: assert property (two_w && cfg_r[5:4] != 2'h0 && $fell(motion.run)
    && !home_done |=> motion.run || home_done) else $error("pause");
  done_still_a: assert property (home_done |-> !motion.run) else $error("done");
  cover property ($rose(home_done));
  cover property (pready && pslverr);
  cover property (go_w && pwdata[2:1] == MODE_PUSH);
endmodule // home_seq_properties

bind return_to_home_sequencer home_seq_properties chk (.core_clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sensors, .step_tick, .motion, .home_done);

// file: testbench/motor_sensor_model.sv
// motor and sensor model: integrates steps into a position, derives sensor levels
// assumes the sequencer's motion command; a step every STEP_GAP cycles while run
`timescale 1ns/100ps
module motor_sensor_model
  import home_seq_pkg::*;
#(
  parameter int STEP_GAP = 4
)(
  input wire logic core_clk, // clock
  input wire logic sys_rst, // clears position
  input wire motion_cmd_t motion, // command
  output sensor_t sensors, // levels
  output logic step_tick, // step pulse
  output int pos // position
);
  int gap_r;
  always_ff @(posedge core_clk) begin
    step_tick <= 1'b0;
    if (sys_rst) begin
      pos <= 0;
      gap_r <= 0;
    end else if (motion.run && gap_r == STEP_GAP - 1) begin
      gap_r <= 0;
      step_tick <= 1'b1;
      pos <= motion.dir_pos ? pos + 1 : pos - 1;
    end else begin
      gap_r <= motion.run ? gap_r + 1 : 0;
    end
  end
  // home 40..50, sensor_input_a 44..47 inside it, limits at +-300, timing every 4th step
  assign sensors.home_sensor = pos >= 40 && pos <= 50;
  assign sensors.positive_limit_sensor = pos >= 300;
  assign sensors.negative_limit_sensor = pos <= -300;
  assign sensors.sensor_input_a = pos >= 44 && pos <= 47;
  assign sensors.step_timing_signal = pos[1:0] == 2'h0;
endmodule // motor_sensor_model

// file: testbench/tb_top.sv
// self-checking bench for the return-to-home sequencer
// assumes the motor model and the bound property checker
`timescale 1ns/100ps
module tb_top
  import home_seq_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sensor_t sens;
  logic tick;
  motion_cmd_t motion;
  logic home_done;
  int pos;
  int failures = 0;
  int checked = 0;
  logic [32:0] q;
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  return_to_home_sequencer uut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sensors(sens), .step_tick(tick), .motion, .home_done);
  motor_sensor_model model (.core_clk, .sys_rst, .motion, .sensors(sens), .step_tick(tick), .pos);
  task automatic print_verdict();
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 20) begin
        failures++;
        print_verdict();
      end
    end while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask
  task automatic go(input logic [31:0] spd, input logic [31:0] ofs, input logic [31:0] ctl);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b1, START_SPEED_ADDR, spd);
    apb(1'b1, OFFSET_ADDR, ofs);
    apb(1'b1, CTRL_ADDR, ctl);
  endtask
  // 0 waits for completion, 1 for the home sensor, 2 for either limit
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (sel == 0 ? home_done !== 1'b1 : sel == 1 ? sens.home_sensor !== 1'b1
      : (sens.positive_limit_sensor | sens.negative_limit_sensor) !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > 6000) begin
        failures++;
        print_verdict();
      end
    end
    repeat (2) @(posedge core_clk);
  endtask
  task automatic t_regs_push();
    cmp(motion, {2'b01, START_SPEED_RESET, RUN_SPEED_RESET});
    rd(CTRL_ADDR, 33'h00000000a);
    rd(RUN_SPEED_ADDR, 33'h0000003e8);
    rd(STATUS_ADDR, 33'h000000100);
    rd(8'h14, 33'h100000000);
    apb(1'b1, CTRL_ADDR, 32'h00000005);
    apb(1'b0, STATUS_ADDR, 32'h0);
    cmp({q[STAT_ERR_BIT], motion.run}, 2'b10);
  endtask
  task automatic t_three_sensor_input_a();
    go(32'h0000012c, 32'h00000003, 32'h0000001b);
    cmp(motion, {2'b11, 20'h0012c, 20'h003e8});
    wait_for(1);
    cmp({motion.run, motion.target_speed}, {1'b1, 20'h0012c});
    wait_for(0);
    cmp(pos, 47);
  endtask
  task automatic t_two_plain();
    go(32'h00000320, 32'h00000000, 32'h00000009);
    wait_for(2);
    cmp({motion.run, motion.dir_pos, motion.target_speed}, {2'b10, 20'h001f4});
    wait_for(0);
    cmp(pos, 99);
  endtask
  task automatic t_two_qual();
    go(32'h00000320, 32'h00fffffe, 32'h00000031);
    rd(OFFSET_ADDR, 33'h0fffffffe);
    wait_for(0);
    cmp(pos, 42);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_regs_push();
    t_three_sensor_input_a();
    t_two_plain();
    t_two_qual();
    print_verdict();
  end
endmodule // tb_top
